// file: verilog/bst_defines.vh
// Constants for the boundary-scan test access port.
// Included by every design file of the block except the synchroniser; definitions only.
`ifndef BST_DEFINES_VH
`define BST_DEFINES_VH

// Controller state codes
`define BST_ST_RESET      4'h0
`define BST_ST_IDLE       4'h1
`define BST_ST_SEL_DR     4'h2
`define BST_ST_CAP_DR     4'h3
`define BST_ST_SHIFT_DR   4'h4
`define BST_ST_EXIT1_DR   4'h5
`define BST_ST_PAUSE_DR   4'h6
`define BST_ST_EXIT2_DR   4'h7
`define BST_ST_UPD_DR     4'h8
`define BST_ST_SEL_IR     4'h9
`define BST_ST_CAP_IR     4'ha
`define BST_ST_SHIFT_IR   4'hb
`define BST_ST_EXIT1_IR   4'hc
`define BST_ST_PAUSE_IR   4'hd
`define BST_ST_EXIT2_IR   4'he
`define BST_ST_UPD_IR     4'hf

// Instruction codes
`define BST_INS_EXTEST    3'h0
`define BST_INS_IDCODE    3'h1
`define BST_INS_SAMPLE    3'h2
`define BST_INS_CLAMP     3'h3
`define BST_INS_HIGHZ     3'h4
`define BST_INS_BYPASS    3'h7

// Fixed value captured into the instruction shift register
`define BST_IR_CAPTURE    3'h1
// Identification code, arbitrary value, bit 0 must be one
`define BST_ID_DEFAULT    32'h0abc_d001
// Boundary chain length default
`define BST_BSR_LEN       8

`endif

// file: verilog/bst_sync.v
// Two flip-flop synchroniser for a vector of pin levels.
// Assumes inputs come from outside core_clk's domain.
`timescale 1ns/1ps
`default_nettype none
module bst_sync #(
   parameter WIDTH = 1
) (
   input wire core_clk, // Sampling clock
   input wire reset, // Synchronous reset, high
   input wire [WIDTH-1:0] din, // Asynchronous levels
   output reg [WIDTH-1:0] dout // Synchronised levels
);
   reg [WIDTH-1:0] meta;

   // First stage is read by the second stage only
   always @(posedge core_clk) begin
      if (reset) begin
         meta <= {WIDTH{1'b0}};
         dout <= {WIDTH{1'b0}};
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // bst_sync
`default_nettype wire

// file: verilog/bst_state.v
// TAP controller next-state logic and state register.
// Assumes rise is a one-cycle core_clk pulse per test clock rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "bst_defines.vh"
module bst_state (
   input wire core_clk, // Core clock
   input wire reset, // Synchronous reset, high
   input wire trst, // Synchronised test port reset, high
   input wire rise, // Test clock rising edge pulse
   input wire tms, // Synchronised mode select
   output reg [3:0] state // Current controller state
);
   reg [3:0] next_state;

   // Graph of the sixteen states
   always @* begin
      case (state)
         `BST_ST_RESET:
            next_state = tms ? `BST_ST_RESET : `BST_ST_IDLE;
         `BST_ST_IDLE:
            next_state = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
         `BST_ST_SEL_DR:
            next_state = tms ? `BST_ST_SEL_IR : `BST_ST_CAP_DR;
         `BST_ST_CAP_DR:
            next_state = tms ? `BST_ST_EXIT1_DR : `BST_ST_SHIFT_DR;
         `BST_ST_SHIFT_DR:
            next_state = tms ? `BST_ST_EXIT1_DR : `BST_ST_SHIFT_DR;
         `BST_ST_EXIT1_DR:
            next_state = tms ? `BST_ST_UPD_DR : `BST_ST_PAUSE_DR;
         `BST_ST_PAUSE_DR:
            next_state = tms ? `BST_ST_EXIT2_DR : `BST_ST_PAUSE_DR;
         `BST_ST_EXIT2_DR:
            next_state = tms ? `BST_ST_UPD_DR : `BST_ST_SHIFT_DR;
         `BST_ST_UPD_DR:
            next_state = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
         `BST_ST_SEL_IR:
            next_state = tms ? `BST_ST_RESET : `BST_ST_CAP_IR;
         `BST_ST_CAP_IR:
            next_state = tms ? `BST_ST_EXIT1_IR : `BST_ST_SHIFT_IR;
         `BST_ST_SHIFT_IR:
            next_state = tms ? `BST_ST_EXIT1_IR : `BST_ST_SHIFT_IR;
         `BST_ST_EXIT1_IR:
            next_state = tms ? `BST_ST_UPD_IR : `BST_ST_PAUSE_IR;
         `BST_ST_PAUSE_IR:
            next_state = tms ? `BST_ST_EXIT2_IR : `BST_ST_PAUSE_IR;
         `BST_ST_EXIT2_IR:
            next_state = tms ? `BST_ST_UPD_IR : `BST_ST_SHIFT_IR;
         `BST_ST_UPD_IR:
            next_state = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
         default:
            next_state = `BST_ST_RESET;
      endcase
   end

   // Moves only on a test clock rise; test reset overrides everything
   always @(posedge core_clk) begin
      if (reset || trst) begin
         state <= `BST_ST_RESET;
      end else if (rise) begin
         state <= next_state;
      end
   end
endmodule // bst_state
`default_nettype wire

// file: verilog/bst_tap.v
// Boundary-scan test access port: controller, instruction register,
// bypass, identification and boundary registers, output control.
// Assumes test pins are asynchronous to core_clk and the test clock
// runs well below a quarter of core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "bst_defines.vh"
module bst_tap #(
   parameter BSR_LEN = `BST_BSR_LEN, // Boundary cells: pins in, then out
   parameter [31:0] ID_CODE = `BST_ID_DEFAULT, // Arbitrary identity value
   parameter NUM_OUT = 4 // Digital output pins under test control
) (
   input wire core_clk, // Core clock, 125 MHz
   input wire reset, // Synchronous reset, high
   input wire test_port_clock, // Test clock pin
   input wire test_port_reset_n, // Test reset pin, low active
   input wire test_serial_in, // Serial data in pin
   input wire test_mode_select, // Mode select pin
   input wire [BSR_LEN-1:0] pin_sample, // Pin levels to capture
   input wire [NUM_OUT-1:0] func_out, // Functional output values
   input wire [NUM_OUT-1:0] func_oe, // Functional output enables
   output reg test_serial_out, // Serial data out
   output reg test_serial_out_oe, // Serial out drive enable
   output reg [NUM_OUT-1:0] pin_out, // Output pin values
   output reg [NUM_OUT-1:0] pin_oe, // Output pin enables
   output reg [2:0] current_instr, // Latched instruction
   output reg [3:0] tap_state // Controller state
);
   wire [3:0] sync_lv;
   wire tck_s;
   wire trst;
   wire tdi_s;
   wire tms_s;
   wire [3:0] state;
   reg tck_d;
   wire rise;
   wire fall;
   reg [2:0] ir_shift;
   reg bypass_bit;
   reg [31:0] id_shift;
   reg [31:0] id_latch;
   reg [BSR_LEN-1:0] bsr_shift;
   reg [BSR_LEN-1:0] bsr_latch;
   reg next_out;
   wire [NUM_OUT-1:0] next_pin_out;
   wire [NUM_OUT-1:0] next_pin_oe;
   wire [1:0] dr_sel;
   wire cap_ir_rise;
   wire shift_ir_rise;
   wire upd_ir_fall;
   wire tlr_fall;
   wire cap_dr_rise;
   wire shift_dr_rise;
   wire upd_dr_fall;
   wire shifting;
   wire bsr_drive;
   wire all_float;
   wire pass_through;
   genvar g;

   // Register selection decoded from an instruction
   function [1:0] sel_of;
      input [2:0] ins;
      begin
         case (ins)
            `BST_INS_EXTEST: sel_of = 2'h1;
            `BST_INS_SAMPLE: sel_of = 2'h1;
            `BST_INS_IDCODE: sel_of = 2'h2;
            default: sel_of = 2'h0;
         endcase
      end
   endfunction

   // True in the two states that put a shifter on the serial output
   function in_shift;
      input [3:0] st;
      begin
         in_shift = (st == `BST_ST_SHIFT_IR) || (st == `BST_ST_SHIFT_DR);
      end
   endfunction

   // True for the instructions that drive pins from the boundary latch
   function from_bsr;
      input [2:0] ins;
      begin
         from_bsr = (ins == `BST_INS_EXTEST) || (ins == `BST_INS_CLAMP);
      end
   endfunction

   // All test pins pass two flip-flops before use
   bst_sync #(
      .WIDTH(4)
   ) u_sync (
      .core_clk(core_clk),
      .reset(reset),
      .din({test_port_clock, ~test_port_reset_n, test_serial_in,
            test_mode_select}),
      .dout(sync_lv)
   );
   assign tck_s = sync_lv[3];
   assign trst = sync_lv[2];
   assign tdi_s = sync_lv[1];
   assign tms_s = sync_lv[0];

   bst_state u_state (
      .core_clk(core_clk),
      .reset(reset),
      .trst(trst),
      .rise(rise),
      .tms(tms_s),
      .state(state)
   );

   // Edge detection of the synchronised test clock
   always @(posedge core_clk) begin
      if (reset) begin
         tck_d <= 1'b0;
      end else begin
         tck_d <= tck_s;
      end
   end
   assign rise = tck_s & ~tck_d;
   assign fall = ~tck_s & tck_d;

   // In Test-Logic-Reset the identification register is selected
   assign dr_sel = (state == `BST_ST_RESET) ? 2'h2 : sel_of(current_instr);

   // Action strobes, one core cycle wide; the state is read before
   // the edge takes effect, so each acts in the state it names
   assign cap_ir_rise = rise && (state == `BST_ST_CAP_IR);
   assign shift_ir_rise = rise && (state == `BST_ST_SHIFT_IR);
   assign upd_ir_fall = fall && (state == `BST_ST_UPD_IR);
   assign tlr_fall = fall && (state == `BST_ST_RESET);
   assign cap_dr_rise = rise && (state == `BST_ST_CAP_DR);
   assign shift_dr_rise = rise && (state == `BST_ST_SHIFT_DR);
   assign upd_dr_fall = fall && (state == `BST_ST_UPD_DR);
   assign shifting = in_shift(state);

   // Instruction shifter and current instruction latch
   always @(posedge core_clk) begin
      if (reset || trst) begin
         ir_shift <= `BST_IR_CAPTURE;
         current_instr <= `BST_INS_IDCODE;
      end else begin
         if (cap_ir_rise) begin
            ir_shift <= `BST_IR_CAPTURE;
         end else if (shift_ir_rise) begin
            ir_shift <= {tdi_s, ir_shift[2:1]};
         end
         // Latch only on the falling edge, so shifting never shows
         if (tlr_fall) begin
            current_instr <= `BST_INS_IDCODE;
         end else if (upd_ir_fall) begin
            current_instr <= ir_shift;
         end
      end
   end

   // Bypass bit: cleared on capture, one stage in the serial path
   always @(posedge core_clk) begin
      if (reset) begin
         bypass_bit <= 1'b0;
      end else if (dr_sel == 2'h0) begin
         if (cap_dr_rise) begin
            bypass_bit <= 1'b0;
         end else if (shift_dr_rise) begin
            bypass_bit <= tdi_s;
         end
      end
   end

   // Identification shifter and latch; unselected, both hold
   always @(posedge core_clk) begin
      if (reset) begin
         id_shift <= 32'h0000_0000;
         id_latch <= 32'h0000_0000;
      end else if (dr_sel == 2'h2) begin
         if (cap_dr_rise) begin
            id_shift <= ID_CODE;
         end else if (shift_dr_rise) begin
            id_shift <= {tdi_s, id_shift[31:1]};
         end
         if (upd_dr_fall) begin
            id_latch <= id_shift;
         end
      end
   end

   // Boundary shifter and latch; while the bypass bit is selected
   // both hold, which is what keeps CLAMP pins frozen
   always @(posedge core_clk) begin
      if (reset) begin
         bsr_shift <= {BSR_LEN{1'b0}};
         bsr_latch <= {BSR_LEN{1'b0}};
      end else if (dr_sel == 2'h1) begin
         if (cap_dr_rise) begin
            bsr_shift <= pin_sample;
         end else if (shift_dr_rise) begin
            bsr_shift <= {tdi_s, bsr_shift[BSR_LEN-1:1]};
         end
         if (upd_dr_fall) begin
            bsr_latch <= bsr_shift;
         end
      end
   end

   // Serial out chooses the active path; changes on the falling edge
   always @* begin
      next_out = test_serial_out;
      if (state == `BST_ST_SHIFT_IR) begin
         next_out = ir_shift[0];
      end else if (state == `BST_ST_SHIFT_DR) begin
         case (dr_sel)
            2'h1: next_out = bsr_shift[0];
            2'h2: next_out = id_shift[0];
            default: next_out = bypass_bit;
         endcase
      end
   end

   // Pin control decoded once from the current instruction
   assign bsr_drive = from_bsr(current_instr);
   assign all_float = (current_instr == `BST_INS_HIGHZ);
   assign pass_through = ~bsr_drive & ~all_float;

   // One control cell per output pin; the low boundary bits feed
   // the pins, so NUM_OUT must not exceed BSR_LEN
   generate
      for (g = 0; g < NUM_OUT; g = g + 1) begin : g_cell
         assign next_pin_out[g] = bsr_drive ? bsr_latch[g] : func_out[g];
         assign next_pin_oe[g] = bsr_drive | (pass_through & func_oe[g]);
      end
   endgenerate

   // Serial out moves on the falling edge only, so the tester gets a
   // settled bit for a full half period; a test reset with the test
   // clock stopped must still release the pin, hence the trst branch
   always @(posedge core_clk) begin
      if (reset) begin
         test_serial_out <= 1'b0;
         test_serial_out_oe <= 1'b0;
      end else if (fall) begin
         test_serial_out <= next_out;
         test_serial_out_oe <= shifting;
      end else if (trst) begin
         test_serial_out_oe <= 1'b0;
      end
   end

   // Pin control and state are registered so every output is a flop
   always @(posedge core_clk) begin
      if (reset) begin
         pin_out <= {NUM_OUT{1'b0}};
         pin_oe <= {NUM_OUT{1'b0}};
         tap_state <= `BST_ST_RESET;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         tap_state <= state;
      end
   end
endmodule // bst_tap
`default_nettype wire

// file: testbench/bst_ctl_model.sv
// Model of the external test controller on the test pins.
// Assumes core_clk at 8 ns; pins move 1 ns after its rise.
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model (
   input wire logic core_clk, // Core clock
   input wire logic tdo, // Device serial out
   output logic tck, // Test clock, 80 ns
   output logic tms, // Mode select
   output logic tdi, // Serial in
   output logic trst_n // Test reset, low
);
   // Clock idles low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      trst_n = 1'b1;
   end
   // Test reset level; called 1 ns after a core clock rise
   task automatic set_trst(input logic v);
      trst_n = v;
   endtask
   // Half a test clock period
   task automatic half;
      repeat (5) @(posedge core_clk);
      #1;
   endtask
   // One bit: set up a half before the rise; serial out moves on
   // the falling edge, so it is read just before the rise
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      half();
      q = tdo;
      tck = 1'b1;
      half();
      tck = 1'b0;
      tdi = ~d; // A released line must not keep its last bit
   endtask
endmodule // bst_ctl_model
`default_nettype wire

// file: testbench/bst_tap_chk.sv
// Checker for the test access port, bound into bst_tap.
// Assumes a slow test clock and the default latencies.
`timescale 1ns/1ps
`default_nettype none
`include "bst_defines.vh"
module bst_tap_chk #(
   parameter NUM_OUT = 4
) (
   input wire logic core_clk, // Clock
   input wire logic reset, // Reset
   input wire logic test_port_clock, // Test clock
   input wire logic test_port_reset_n, // Test reset
   input wire logic [NUM_OUT-1:0] func_out, // Func values
   input wire logic [NUM_OUT-1:0] func_oe, // Func enables
   input wire logic test_serial_out_oe, // Serial enable
   input wire logic [NUM_OUT-1:0] pin_out, // Pin values
   input wire logic [NUM_OUT-1:0] pin_oe, // Pin enables
   input wire logic [2:0] current_instr, // Instruction
   input wire logic [3:0] tap_state // State
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   chk_state_edge: assert property ($changed(tap_state) &&
      test_port_reset_n |-> $past(test_port_clock, 3))
      else $error("state moved off a rise");
   chk_reset_vals: assert property ($fell(reset) |->
      tap_state == `BST_ST_RESET && current_instr == `BST_INS_IDCODE)
      else $error("bad reset values");
   chk_trst_force: assert property (!test_port_reset_n [*6] |->
      tap_state == `BST_ST_RESET && current_instr == `BST_INS_IDCODE)
      else $error("test reset ignored");
   chk_instr_upd: assert property ($changed(current_instr) |->
      tap_state inside {`BST_ST_UPD_IR, `BST_ST_RESET} || !test_port_reset_n)
      else $error("instruction moved");
   chk_oe_shift: assert property (test_serial_out_oe |-> tap_state
      inside {`BST_ST_SHIFT_DR, `BST_ST_EXIT1_DR, `BST_ST_SHIFT_IR,
      `BST_ST_EXIT1_IR}) else $error("serial out driven idle");
   chk_highz_oe: assert property (current_instr == `BST_INS_HIGHZ [*3]
      |-> pin_oe == '0) else $error("pins not floated");
   chk_func_pass: assert property ((current_instr inside
      {`BST_INS_SAMPLE, `BST_INS_BYPASS, `BST_INS_IDCODE} &&
      $stable(func_out) && $stable(func_oe)) [*3] |->
      pin_out == func_out && pin_oe == func_oe) else $error("pins disturbed");
   chk_clamp_hold: assert property (current_instr == `BST_INS_CLAMP [*3]
      |-> $stable(pin_out)) else $error("clamped pins moved");
   cover property (tap_state == `BST_ST_PAUSE_DR);
   cover property (tap_state == `BST_ST_PAUSE_IR);
   cover property (current_instr == `BST_INS_HIGHZ);
endmodule // bst_tap_chk
bind bst_tap bst_tap_chk #(.NUM_OUT(NUM_OUT)) u_chk (
   .core_clk(core_clk), .reset(reset), .test_port_clock(test_port_clock),
   .test_port_reset_n(test_port_reset_n), .func_out(func_out),
   .func_oe(func_oe), .test_serial_out_oe(test_serial_out_oe),
   .pin_out(pin_out), .pin_oe(pin_oe), .current_instr(current_instr),
   .tap_state(tap_state));
`default_nettype wire

// file: testbench/bst_tap_tb.sv
// Testbench for the test access port, driven via the model.
// Assumes the default identity value and chain length.
`timescale 1ns/1ps
`default_nettype none
`include "bst_defines.vh"
module bst_tap_tb;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] pin_sample = 8'h00;
   logic [3:0] func_out = 4'h0;
   logic [3:0] func_oe = 4'hf;
   wire tck, tms, tdi, trst_n, tdo, oe;
   wire [3:0] pin_out, pin_oe, st;
   wire [2:0] cur;
   int err_total = 0;
   int check_count = 0;
   logic q;
   logic [31:0] so;
   // Core clock, 8 ns
   always #4 core_clk = ~core_clk;
   bst_ctl_model ctl (.core_clk(core_clk), .tdo(tdo), .tck(tck),
      .tms(tms), .tdi(tdi), .trst_n(trst_n));
   bst_tap dut (.core_clk(core_clk), .reset(reset),
      .test_port_clock(tck), .test_port_reset_n(trst_n),
      .test_serial_in(tdi), .test_mode_select(tms),
      .pin_sample(pin_sample), .func_out(func_out), .func_oe(func_oe),
      .test_serial_out(tdo), .test_serial_out_oe(oe), .pin_out(pin_out),
      .pin_oe(pin_oe), .current_instr(cur), .tap_state(st));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One clock with serial in low; state is read once it has landed
   task automatic tk(input logic m, input logic [3:0] e);
      ctl.step(m, 1'b0, q);
      repeat (2) @(posedge core_clk);
      #1;
      check(st, e);
   endtask
   // Scan n bits LSB first from idle back to idle, pausing after bit p
   task automatic scan(input logic ir, input int n, input logic [31:0] d,
      input int p);
      so = '0;
      tk(1'b1, `BST_ST_SEL_DR);
      if (ir)
         tk(1'b1, `BST_ST_SEL_IR);
      tk(1'b0, ir ? `BST_ST_CAP_IR : `BST_ST_CAP_DR);
      tk(1'b0, ir ? `BST_ST_SHIFT_IR : `BST_ST_SHIFT_DR);
      for (int i = 0; i < n; i++) begin
         ctl.step(i == n - 1 || i == p, d[i], so[i]);
         if (i == 0)
            check(oe, 1'b1);
         if (i == p && i < n - 1) begin
            tk(1'b0, ir ? `BST_ST_PAUSE_IR : `BST_ST_PAUSE_DR);
            tk(1'b0, ir ? `BST_ST_PAUSE_IR : `BST_ST_PAUSE_DR);
            tk(1'b1, ir ? `BST_ST_EXIT2_IR : `BST_ST_EXIT2_DR);
            tk(1'b0, ir ? `BST_ST_SHIFT_IR : `BST_ST_SHIFT_DR);
         end
      end
      tk(1'b1, ir ? `BST_ST_UPD_IR : `BST_ST_UPD_DR);
      tk(1'b0, `BST_ST_IDLE);
   endtask
   // Load an instruction; the fixed capture value comes out first
   task automatic ld(input logic [2:0] c, input int p);
      scan(1'b1, 3, {29'h0, c}, p);
      check(so, 32'h1);
      check(cur, c);
      check(oe, 1'b0);
   endtask
   task automatic t_reset;
      check(st, `BST_ST_RESET);
      check(cur, `BST_INS_IDCODE);
      tk(1'b1, `BST_ST_RESET);
      tk(1'b0, `BST_ST_IDLE);
      tk(1'b0, `BST_ST_IDLE);
      $display("reset done");
   endtask
   // Identity read, pausing halfway and mid instruction load
   task automatic t_ident;
      ld(`BST_INS_IDCODE, 0);
      scan(1'b0, 32, 32'h0, 15);
      check(so, `BST_ID_DEFAULT);
      $display("identity done");
   endtask
   // Bypass captures zero, then delays the stream by one bit
   task automatic t_bypass;
      ld(`BST_INS_BYPASS, 9);
      scan(1'b0, 4, 32'hb, 9);
      check(so, 32'h6);
      $display("bypass done");
   endtask
   // Capture and preload, then drive, clamp and float the pins
   task automatic t_bound;
      pin_sample = 8'h5a;
      func_out = 4'h9;
      ld(`BST_INS_SAMPLE, 9);
      scan(1'b0, 8, 32'h3c, 9);
      check(so, 32'h5a);
      check(pin_out, 4'h9);
      pin_sample = 8'ha5;
      ld(`BST_INS_EXTEST, 1);
      check(pin_out, 4'hc);
      scan(1'b0, 8, 32'h3c, 9);
      check(so, 32'ha5);
      ld(`BST_INS_CLAMP, 9);
      func_out = 4'h3;
      scan(1'b0, 2, 32'h1, 9);
      check(so, 32'h2);
      check(pin_out, 4'hc);
      ld(`BST_INS_HIGHZ, 9);
      scan(1'b0, 2, 32'h1, 9);
      check(so, 32'h2);
      check(pin_oe, 4'h0);
      $display("boundary done");
   endtask
   // Reset pin, then the mode-select path back into reset
   task automatic t_trst;
      ctl.set_trst(1'b0);
      repeat (10) @(posedge core_clk);
      #1;
      check(st, `BST_ST_RESET);
      check(cur, `BST_INS_IDCODE);
      check(oe, 1'b0);
      ctl.set_trst(1'b1);
      repeat (5) @(posedge core_clk);
      #1;
      tk(1'b0, `BST_ST_IDLE);
      ld(`BST_INS_BYPASS, 9);
      tk(1'b1, `BST_ST_SEL_DR);
      tk(1'b1, `BST_ST_SEL_IR);
      tk(1'b1, `BST_ST_RESET);
      // The reload waits for the fall to clear the synchroniser
      repeat (2) @(posedge core_clk);
      #1;
      check(cur, `BST_INS_IDCODE);
      $display("test reset done");
   endtask
   // Reset for 20 cycles, run the scenarios, then judge
   initial begin
      repeat (20) @(posedge core_clk);
      #1;
      reset = 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      t_reset();
      t_ident();
      t_bypass();
      t_bound();
      t_trst();
      test_done();
   end
   // Watchdog: the run needs well under 100 us
   initial begin
      #400000;
      err_total++;
      test_done();
   end
endmodule // bst_tap_tb
`default_nettype wire
